// ==== hdl/agu_pkg.sv ====
// Package of register offsets, fields, reset values and mode codes for the address unit.
package agu_pkg;
  localparam logic [11:0] ADDR_CIRC_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_X_START    = 12'h004;
  localparam logic [11:0] ADDR_X_END      = 12'h008;
  localparam logic [11:0] ADDR_BREV_CTRL  = 12'h00c;
  localparam logic [11:0] ADDR_TBL_PAGE   = 12'h010;
  localparam logic [11:0] ADDR_VIS_PAGE   = 12'h014;
  localparam logic [11:0] ADDR_STATUS     = 12'h018;
  localparam int          CIRC_EN_BIT     = 15;
  localparam int          REV_SEL_LSB     = 8;
  localparam int          REV_EN_BIT      = 15;
  localparam logic [3:0]  SEL_NONE        = 4'hf;
  localparam logic [15:0] CIRC_CTRL_RST   = 16'h0fff;
  localparam logic [15:0] BREV_CTRL_RST   = 16'h0000;
  localparam logic [15:0] X_START_RST     = 16'h0000;
  localparam logic [15:0] X_END_RST       = 16'h0000;
  localparam logic [7:0]  PAGE_RST        = 8'h00;
  typedef enum logic [2:0] {
    AGU_MODE_IND      = 3'h0,
    AGU_MODE_POST_INC = 3'h1,
    AGU_MODE_POST_DEC = 3'h2,
    AGU_MODE_PRE_INC  = 3'h3,
    AGU_MODE_PRE_DEC  = 3'h4,
    AGU_MODE_REG_OFS  = 3'h5
  } agu_mode_t;
  typedef enum logic [1:0] {
    AGU_PS_NONE  = 2'b00,
    AGU_PS_TABLE = 2'b01,
    AGU_PS_VIS   = 2'b11
  } agu_ps_t;
endpackage

// ==== hdl/agu_bitrev_modulo_progspace.sv ====
// Address generation: circular correction, bit reversal and program-space addresses.
module agu_bitrev_modulo_progspace (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire logic                req_byte,
  input  wire agu_pkg::agu_mode_t  req_mode,
  input  wire logic [3:0]          req_reg,
  input  wire logic [15:0]         req_ptr,
  input  wire logic [15:0]         req_ofs,
  output logic                     ea_valid,
  output logic      [15:0]         ea,
  output logic                     wb_en,
  output logic      [3:0]          wb_reg,
  output logic      [15:0]         wb_data,
  output logic                     ea_reversed,
  output logic                     ea_wrapped,
  input  wire logic                ps_valid,
  input  wire agu_pkg::agu_ps_t    ps_kind,
  input  wire logic                ps_write,
  input  wire logic [15:0]         ps_ea,
  output logic                     pa_valid,
  output logic      [23:0]         pa,
  output logic                     pa_config,
  output logic                     pa_low_word,
  output logic                     pa_refused
);
  import agu_pkg::*;

  logic [15:0] circ_ctrl_r, circ_ctrl_nxt;
  logic [15:0] x_start_r, x_start_nxt;
  logic [15:0] x_end_r, x_end_nxt;
  logic [15:0] brev_ctrl_r, brev_ctrl_nxt;
  logic [7:0]  tbl_page_r, tbl_page_nxt;
  logic [7:0]  vis_page_r, vis_page_nxt;
  logic [1:0]  status_r, status_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        pready_r, pready_nxt;
  logic        apb_acc;
  logic        addr_ok;

  // Decode and result of one data request, shared with the status register.
  logic [3:0]  circ_sel;
  logic [3:0]  rev_sel;
  logic        circ_on;
  logic        rev_cfg;
  logic        is_inc;
  logic        is_dec;
  logic        is_pre;
  logic        is_mod;
  logic        rev_act;
  logic [14:0] pivot_rev;
  logic [15:0] pivot_rev_b;
  logic [15:0] step;
  logic [15:0] raw;
  logic [15:0] mod_ea;
  logic [15:0] rev_ea;
  logic        wrapped;
  logic [15:0] len;
  logic        ea_valid_nxt;
  logic [15:0] ea_nxt;
  logic        wb_en_nxt;
  logic [15:0] wb_data_nxt;
  logic        ea_reversed_nxt;
  logic        ea_wrapped_nxt;

  assign apb_acc = psel && penable;
  // One wait state lets the registered read data and error stand while pready is high.
  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      ADDR_CIRC_CTRL, ADDR_X_START, ADDR_X_END, ADDR_BREV_CTRL,
      ADDR_TBL_PAGE, ADDR_VIS_PAGE, ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Register writes, read mux and sticky status of the last generated address.
  always_comb begin
    circ_ctrl_nxt = circ_ctrl_r;
    x_start_nxt   = x_start_r;
    x_end_nxt     = x_end_r;
    brev_ctrl_nxt = brev_ctrl_r;
    tbl_page_nxt  = tbl_page_r;
    vis_page_nxt  = vis_page_r;
    prdata_nxt    = prdata_r;
    pslverr_nxt   = 1'b0;
    status_nxt    = status_r;
    if (ea_valid_nxt) begin
      status_nxt = {rev_act, wrapped};
    end
    pready_nxt    = apb_acc && !pready_r;
    if (apb_acc && !pready_r) begin
      pslverr_nxt = !addr_ok;
    end
    if (apb_acc) begin
      // Writes commit only at the edge that completes the access.
      if (pwrite && pready_r) begin
        case (paddr)
          ADDR_CIRC_CTRL: circ_ctrl_nxt = pwdata[15:0];
          ADDR_X_START:   x_start_nxt   = pwdata[15:0];
          ADDR_X_END:     x_end_nxt     = pwdata[15:0];
          ADDR_BREV_CTRL: brev_ctrl_nxt = pwdata[15:0];
          ADDR_TBL_PAGE:  tbl_page_nxt  = pwdata[7:0];
          ADDR_VIS_PAGE:  vis_page_nxt  = pwdata[7:0];
          default: ;
        endcase
      end else if (!pwrite && !pready_r) begin
        case (paddr)
          ADDR_CIRC_CTRL: prdata_nxt = {16'h0000, circ_ctrl_r};
          ADDR_X_START:   prdata_nxt = {16'h0000, x_start_r};
          ADDR_X_END:     prdata_nxt = {16'h0000, x_end_r};
          ADDR_BREV_CTRL: prdata_nxt = {16'h0000, brev_ctrl_r};
          ADDR_TBL_PAGE:  prdata_nxt = {24'h000000, tbl_page_r};
          ADDR_VIS_PAGE:  prdata_nxt = {24'h000000, vis_page_r};
          ADDR_STATUS:    prdata_nxt = {30'h0, status_r};
          default:        prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bit reversal and circular correction for one data request.
  assign circ_sel = circ_ctrl_r[3:0];
  assign rev_sel  = circ_ctrl_r[REV_SEL_LSB +: 4];
  assign circ_on  = circ_ctrl_r[CIRC_EN_BIT] && (circ_sel != SEL_NONE);
  assign rev_cfg  = (rev_sel != SEL_NONE) && brev_ctrl_r[REV_EN_BIT];

  // The modifier is mirrored here; the pointer is mirrored inside the reverse-carry add.
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi++) begin : g_mirror
      assign pivot_rev[gi] = brev_ctrl_r[14 - gi];
    end
  endgenerate

  always_comb begin
    is_inc = (req_mode == AGU_MODE_POST_INC) || (req_mode == AGU_MODE_PRE_INC);
    is_dec = (req_mode == AGU_MODE_POST_DEC) || (req_mode == AGU_MODE_PRE_DEC);
    is_pre = (req_mode == AGU_MODE_PRE_INC) || (req_mode == AGU_MODE_PRE_DEC);
    is_mod = is_inc || is_dec;
    rev_act = rev_cfg && req_write && !req_byte && is_inc
              && (req_reg == rev_sel);
    // Reverse-carry add: mirror pointer, add mirrored word pivot, mirror back.
    pivot_rev_b = {pivot_rev, 1'b0};
    rev_ea = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      rev_ea[i] = 1'b0;
    end
    begin : b_rev
      logic [15:0] pm;
      logic [15:0] sm;
      pm = 16'h0000;
      sm = 16'h0000;
      for (int i = 1; i < 16; i++) begin
        pm[i] = req_ptr[16 - i];
      end
      // Carries run towards the lsb of the pointer, as the mirrored sum requires.
      sm = pm + pivot_rev_b;
      for (int i = 1; i < 16; i++) begin
        rev_ea[16 - i] = sm[i];
      end
      rev_ea[0] = 1'b0;
    end
    step = req_byte ? 16'h0001 : 16'h0002;
    case (req_mode)
      AGU_MODE_POST_INC: raw = req_ptr + step;
      AGU_MODE_POST_DEC: raw = req_ptr - step;
      AGU_MODE_PRE_INC:  raw = req_ptr + step;
      AGU_MODE_PRE_DEC:  raw = req_ptr - step;
      AGU_MODE_REG_OFS:  raw = req_ptr + req_ofs;
      default:           raw = req_ptr;
    endcase
    len = x_end_r - x_start_r + 16'h0001;
    mod_ea  = raw;
    wrapped = 1'b0;
    if (circ_on && !rev_act && (req_reg == circ_sel)) begin
      if (raw > x_end_r) begin
        mod_ea  = raw - len;
        wrapped = 1'b1;
      end else if (raw < x_start_r) begin
        mod_ea  = raw + len;
        wrapped = 1'b1;
      end
    end
    ea_valid_nxt    = req_valid;
    ea_reversed_nxt = req_valid && rev_act;
    ea_wrapped_nxt  = req_valid && wrapped;
    wb_en_nxt       = req_valid && (is_mod || rev_act);
    if (rev_act) begin
      ea_nxt      = is_pre ? rev_ea : {req_ptr[15:1], 1'b0};
      wb_data_nxt = rev_ea;
    end else begin
      ea_nxt      = (is_mod && !is_pre) ? req_ptr : mod_ea;
      wb_data_nxt = mod_ea;
    end
  end

  // Program-space address construction.
  logic        pa_valid_nxt;
  logic [23:0] pa_nxt;
  logic        pa_config_nxt;
  logic        pa_low_word_nxt;
  logic        pa_refused_nxt;

  always_comb begin
    pa_valid_nxt    = 1'b0;
    pa_nxt          = 24'h000000;
    pa_config_nxt   = 1'b0;
    pa_low_word_nxt = 1'b0;
    pa_refused_nxt  = 1'b0;
    if (ps_valid) begin
      case (ps_kind)
        AGU_PS_TABLE: begin
          pa_valid_nxt  = 1'b1;
          pa_nxt        = {tbl_page_r, ps_ea};
          pa_config_nxt = tbl_page_r[7];
        end
        AGU_PS_VIS: begin
          if (ps_write || !ps_ea[15]) begin
            pa_refused_nxt = 1'b1;
          end else begin
            pa_valid_nxt    = 1'b1;
            pa_low_word_nxt = 1'b1;
            pa_nxt = {1'b0, vis_page_r, ps_ea[14:1], 1'b0};
          end
        end
        default: ;
      endcase
    end
  end

  // Register file and bus answer.
  always_ff @(posedge clk) begin
    if (reset) begin
      circ_ctrl_r <= CIRC_CTRL_RST;
      x_start_r   <= X_START_RST;
      x_end_r     <= X_END_RST;
      brev_ctrl_r <= BREV_CTRL_RST;
      tbl_page_r  <= PAGE_RST;
      vis_page_r  <= PAGE_RST;
      status_r    <= 2'b00;
      prdata_r    <= 32'h0000_0000;
      pslverr_r   <= 1'b0;
      pready_r    <= 1'b0;
    end else begin
      circ_ctrl_r <= circ_ctrl_nxt;
      x_start_r   <= x_start_nxt;
      x_end_r     <= x_end_nxt;
      brev_ctrl_r <= brev_ctrl_nxt;
      tbl_page_r  <= tbl_page_nxt;
      vis_page_r  <= vis_page_nxt;
      status_r    <= status_nxt;
      prdata_r    <= prdata_nxt;
      pslverr_r   <= pslverr_nxt;
      pready_r    <= pready_nxt;
    end
  end

  // Answer of one data request, a pulse in the cycle after it is taken.
  always_ff @(posedge clk) begin
    if (reset) begin
      ea_valid    <= 1'b0;
      ea          <= 16'h0000;
      wb_en       <= 1'b0;
      wb_reg      <= 4'h0;
      wb_data     <= 16'h0000;
      ea_reversed <= 1'b0;
      ea_wrapped  <= 1'b0;
    end else begin
      ea_valid    <= ea_valid_nxt;
      ea          <= ea_nxt;
      wb_en       <= wb_en_nxt;
      wb_reg      <= req_reg;
      wb_data     <= wb_data_nxt;
      ea_reversed <= ea_reversed_nxt;
      ea_wrapped  <= ea_wrapped_nxt;
    end
  end

  // Answer of one program-space request, a pulse in the cycle after it is taken.
  always_ff @(posedge clk) begin
    if (reset) begin
      pa_valid    <= 1'b0;
      pa          <= 24'h000000;
      pa_config   <= 1'b0;
      pa_low_word <= 1'b0;
      pa_refused  <= 1'b0;
    end else begin
      pa_valid    <= pa_valid_nxt;
      pa          <= pa_nxt;
      pa_config   <= pa_config_nxt;
      pa_low_word <= pa_low_word_nxt;
      pa_refused  <= pa_refused_nxt;
    end
  end
endmodule // agu_bitrev_modulo_progspace

// ==== bench/agu_props.sv ====
// Concurrent checks on the address unit ports.
module agu_props (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               req_valid,
  input wire logic               req_write,
  input wire logic               req_byte,
  input wire agu_pkg::agu_mode_t req_mode,
  input wire logic               ea_valid,
  input wire logic [15:0]        ea,
  input wire logic               wb_en,
  input wire logic               ea_reversed,
  input wire logic               ea_wrapped,
  input wire logic               ps_valid,
  input wire agu_pkg::agu_ps_t   ps_kind,
  input wire logic               ps_write,
  input wire logic [15:0]        ps_ea,
  input wire logic               pa_valid,
  input wire logic [23:0]        pa,
  input wire logic               pa_config,
  input wire logic               pa_low_word,
  input wire logic               pa_refused
);
  import agu_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence vis_rd_s;
    ps_valid && ps_kind == AGU_PS_VIS && !ps_write && ps_ea[15];
  endsequence
  sequence pa_user_s;
    pa_valid && !pa_refused && !pa[23];
  endsequence
  ea_answer_a: assert property (req_valid |=> ea_valid)
    else $error("request without address answer");
  wb_hold_a: assert property (req_valid && req_mode inside {AGU_MODE_IND, AGU_MODE_REG_OFS} |=> !wb_en)
    else $error("pointer written back in offset mode");
  rev_read_a: assert property (req_valid && (!req_write || req_byte) |=> !ea_reversed)
    else $error("reversal on read or byte access");
  rev_mode_a: assert property (req_valid && !(req_mode inside {AGU_MODE_POST_INC, AGU_MODE_PRE_INC}) |=> !ea_reversed)
    else $error("reversal outside increment modes");
  rev_lsb_a: assert property (ea_valid && ea_reversed |-> !ea[0])
    else $error("reversed address not word aligned");
  rev_prio_a: assert property (ea_reversed |-> !ea_wrapped)
    else $error("wrap applied to reversed write");
  vis_addr_a: assert property (vis_rd_s |=> pa_user_s ##0 (pa_low_word && pa[14:0] == {$past(ps_ea[14:1]), 1'b0}))
    else $error("visibility address wrong");
  vis_write_a: assert property (ps_valid && ps_kind == AGU_PS_VIS && ps_write |=> !pa_valid && pa_refused)
    else $error("visibility write not refused");
  tbl_addr_a: assert property (ps_valid && ps_kind == AGU_PS_TABLE |=> pa[15:0] == $past(ps_ea) && pa_config == pa[23] && !pa_refused)
    else $error("table address wrong");
endmodule // agu_props

bind agu_bitrev_modulo_progspace agu_props agu_props_i (.*);

// ==== bench/agu_core_model.sv ====
// Core register file model that serves pointers and takes write-backs.
module agu_core_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  req_reg,
  output logic      [15:0] req_ptr,
  input  wire logic        wb_en,
  input  wire logic [3:0]  wb_reg,
  input  wire logic [15:0] wb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs_r [16];
  assign req_ptr = regs_r[req_reg];
  always @(posedge clk) begin
    for (int i = 0; i < 16; i++) begin
      if (reset) begin
        regs_r[i] <= 16'(i) << 8;
      end else if (wb_en && wb_reg == 4'(i)) begin
        regs_r[i] <= wb_data;
      end
    end
  end
endmodule // agu_core_model

// ==== bench/tb_agu_bitrev_modulo_progspace.sv ====
// Self-checking bench for the address unit.
module tb_agu_bitrev_modulo_progspace import agu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic req_valid = 0, req_write = 0, req_byte = 0, ps_valid = 0, ps_write = 0;
  logic ea_valid, wb_en, ea_reversed, ea_wrapped, pa_valid, pa_config, pa_low_word, pa_refused;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0]  req_reg = '0, wb_reg;
  logic [15:0] req_ptr, req_ofs = '0, ea, wb_data, ps_ea = '0;
  logic [23:0] pa;
  agu_mode_t   req_mode = AGU_MODE_IND;
  agu_ps_t     ps_kind = AGU_PS_NONE;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  always #4 clk = ~clk;
  agu_bitrev_modulo_progspace agu_bitrev_modulo_progspace_i (.*);
  agu_core_model agu_core_model_i (.*);
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Leaves the request raised so a following access can chain straight into its setup.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask
  task automatic wr(logic [11:0] a, logic [15:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {16'h0000, d}, q, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp, logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk("prdata", exp, q);
    chk("pslverr", 32'(exp_err), 32'(e));
  endtask
  task automatic req(logic w, logic b, agu_mode_t m, logic [3:0] r, logic [15:0] o,
                     logic [15:0] e_ea, logic e_wb, logic [15:0] e_wd, logic [1:0] e_fl);
    req_valid <= 1'b1;
    req_write <= w;
    req_byte <= b;
    req_mode <= m;
    req_reg <= r;
    req_ofs <= o;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk("ea_valid", 32'h1, 32'(ea_valid));
    chk("wb_reg", 32'(r), 32'(wb_reg));
    chk("ea", 32'(e_ea), 32'(ea));
    chk("wb_en", 32'(e_wb), 32'(wb_en));
    if (e_wb) chk("wb_data", 32'(e_wd), 32'(wb_data));
    chk("rev_wrap", 32'(e_fl), 32'({ea_reversed, ea_wrapped}));
    @(posedge clk);
  endtask
  task automatic ps(agu_ps_t k, logic w, logic [15:0] a, logic [23:0] e_pa, logic [1:0] e_fl);
    ps_valid <= 1'b1;
    ps_kind <= k;
    ps_write <= w;
    ps_ea <= a;
    @(posedge clk);
    ps_valid <= 1'b0;
    @(negedge clk);
    chk("pa_valid", 32'(e_pa !== 24'h0), 32'(pa_valid));
    chk("pa_refused", 32'(e_pa === 24'h0), 32'(pa_refused));
    if (e_pa !== 24'h0) chk("pa", 32'(e_pa), 32'(pa));
    if (e_pa !== 24'h0) chk("pa_flags", 32'(e_fl), 32'({pa_config, pa_low_word}));
    @(posedge clk);
  endtask
  task automatic t_regs();
    rd(ADDR_CIRC_CTRL, 32'h0000_0fff, 1'b0);
    rd(ADDR_BREV_CTRL, 32'h0, 1'b0);
    rd(12'h0ff, 32'h0, 1'b1);
    wr(ADDR_BREV_CTRL, 16'h7fff);
    rd(ADDR_BREV_CTRL, 32'h0000_7fff, 1'b0);
  endtask
  task automatic t_rev();
    logic [15:0] idx [5];
    idx = '{16'h0, 16'h8, 16'h4, 16'hc, 16'h2};
    wr(ADDR_CIRC_CTRL, 16'h020f);
    wr(ADDR_BREV_CTRL, 16'h8008);
    for (int i = 0; i < 4; i++) begin
      req(1, 0, AGU_MODE_POST_INC, 2, 0, 16'h200 + 2 * idx[i], 1, 16'h200 + 2 * idx[i + 1], 2);
    end
    req(0, 0, AGU_MODE_POST_INC, 2, 0, 16'h204, 1, 16'h206, 0);
    req(1, 1, AGU_MODE_POST_INC, 2, 0, 16'h206, 1, 16'h207, 0);
    req(1, 0, AGU_MODE_PRE_INC, 2, 0, 16'h216, 1, 16'h216, 2);
    req(1, 0, AGU_MODE_POST_DEC, 2, 0, 16'h216, 1, 16'h214, 0);
  endtask
  task automatic t_circ();
    wr(ADDR_X_START, 16'h0300);
    wr(ADDR_X_END, 16'h030f);
    wr(ADDR_CIRC_CTRL, 16'h8303);
    req(0, 0, AGU_MODE_PRE_DEC, 3, 0, 16'h30e, 1, 16'h30e, 1);
    req(0, 0, AGU_MODE_REG_OFS, 3, 4, 16'h302, 0, 0, 1);
    req(1, 0, AGU_MODE_POST_INC, 3, 0, 16'h30e, 1, 16'h31e, 2);
    rd(ADDR_STATUS, 32'h0000_0002, 1'b0);
    wr(ADDR_CIRC_CTRL, 16'h8f0f);
    req(0, 0, AGU_MODE_REG_OFS, 3, 0, 16'h31e, 0, 0, 0);
  endtask
  task automatic t_prog();
    wr(ADDR_TBL_PAGE, 16'h0085);
    wr(ADDR_VIS_PAGE, 16'h005b);
    ps(AGU_PS_TABLE, 0, 16'h1235, 24'h851235, 2);
    wr(ADDR_TBL_PAGE, 16'h0005);
    ps(AGU_PS_TABLE, 1, 16'h1234, 24'h051234, 0);
    ps(AGU_PS_VIS, 0, 16'h9235, 24'h2d9234, 1);
    ps(AGU_PS_VIS, 1, 16'h9234, 24'h0, 0);
    ps(AGU_PS_VIS, 0, 16'h1234, 24'h0, 0);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rev();
    t_circ();
    t_prog();
    tally_and_finish();
  end
endmodule // tb_agu_bitrev_modulo_progspace
